/* hdl/dcs_pkg.sv */
// shared constants and carriers for the driver diagnostics and clock supervisor
package dcs_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int OSC_HZ = 14_000_000;
	// internal oscillator modelled as an enable pulse from a divider
	localparam int OSC_DIV = (CLK_HZ / OSC_HZ < 1) ? 1 : CLK_HZ / OSC_HZ;
	localparam int STANDSTILL_FLAG_CYCLES = 1 << 20;
	localparam int FS_MIN_OSC = 32;
	localparam int FS_MAX_OSC = 48;

	localparam logic [7:0] TEMP_WARN = 8'h64;
	localparam logic [7:0] TEMP_RELEASE = 8'h78;
	localparam logic [7:0] TEMP_SD_HIGH = 8'h96;
	localparam logic [7:0] TEMP_SD_LOW = 8'h88;

	localparam logic [7:0] CUR_MAX = 8'hFF;
	localparam int CUR_DIV_SHIFT = 4;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [2:0] GATE_MAX = 3'h7;

	// bit positions of status bits carried on every read
	localparam int RD_OLA = 31;
	localparam int RD_OLB = 30;
	localparam int RD_WARN = 29;
	localparam int RD_OT = 28;
	localparam int RD_STANDSTILL_FLAG = 27;

	typedef struct packed {
		logic [4:0] current_scale;
		logic [3:0] chopper_off_time;
		logic gate_temp_comp;
		logic [2:0] high_side_gate_strength;
		logic clock_failsafe_enable;
		logic low_supply_mode;
		logic thermal_limit_select;
	} dcs_ctrl_t;

	typedef struct packed {
		logic ola;
		logic olb;
		logic thermal_warning_flag;
		logic thermal_shutdown_flag;
		logic standstill_flag;
	} dcs_flags_t;

	typedef struct packed {
		logic [1:0] chop_evt;
		logic [1:0] polarity;
		logic [7:0] cur_a;
		logic [7:0] cur_b;
	} dcs_coil_t;
endpackage

/* hdl/dcs_supervisor.sv */
// diagnostics, thermal, undervoltage and clock supervision with Wishbone registers
//
// Overview of operation
// - open-load set if no chop in polarity period
// - open-load frozen below one sixteenth current
// - open-load flags drive no protective action
// - warn 100, release 120, selectable shutdown
// - shutdown holds bridges off until below 120
// - compensated gate mode adds one step warm
// - warning flag high while prewarning reached
// - shutdown flag high while overtemperature holds bridges off
// - limit select: 0 is 150, 1 is 136
// - undervoltage resets logic, bridges off, regs zero
// - current scale cleared, readback field reads zero
// - low supply bit picks 7V or 4.5V threshold
// - during power-up bus held reset, no answer
// - standstill flag after 2^20 cycles without step
// - run internal until first external high level
// - no failsafe: lost external clock halts logic
// - failsafe restores clock after 32 to 48 ticks
// - short-to-ground cut works without any clock
// - disable pin or zero off time frees motor
//
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module dcs_supervisor #(
	parameter int STANDSTILL_FLAG_CYCLES = dcs_pkg::STANDSTILL_FLAG_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic power_up_busy,
	input wire logic supply_below_7v,
	input wire logic supply_below_4v5,
	input wire logic [7:0] temp_deg,
	input wire dcs_pkg::dcs_coil_t coil_i,
	input wire logic step_pulse,
	input wire logic ext_clk_level,
	input wire logic bridge_disable_pin,
	input wire logic short_to_ground,
	output logic bridge_enable,
	output logic [2:0] gate_strength,
	output logic low_side_protect_en,
	output logic damping_enable,
	output logic ext_clock_selected,
	output logic osc_enable,
	output logic logic_halted,
	output dcs_pkg::dcs_flags_t flags_o
);
	////////////////////////////////////////////////////////////////////////////
	// reset sources
	logic uv_now;
	logic rst_int;
	dcs_pkg::dcs_ctrl_t ctrl_q;

	// threshold follows the register, which itself falls to the 7V choice on reset
	assign uv_now = ctrl_q.low_supply_mode ? supply_below_4v5 : supply_below_7v;
	assign rst_int = sys_rst | uv_now | power_up_busy;

	////////////////////////////////////////////////////////////////////////////
	// clock source supervision
	logic [7:0] osc_div_q;
	logic osc_tick;
	logic ext_prev_q;
	logic ext_sel_q;
	logic fail_q;
	logic halt_q;
	logic [5:0] watch_q;
	logic ext_rise;
	logic run;

	function automatic logic at_or_above(input logic [7:0] a, input logic [7:0] b);
		at_or_above = (a >= b);
	endfunction

	assign osc_tick = (osc_div_q == 8'((dcs_pkg::OSC_DIV) - 1));
	assign ext_rise = ext_clk_level & ~ext_prev_q;
	assign run = ~halt_q;

	always_ff @(posedge clk_sys) begin
		if (rst_int || osc_tick) begin
			osc_div_q <= 8'h00;
		end else begin
			osc_div_q <= osc_div_q + 8'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			ext_prev_q <= 1'b0;
		end else begin
			ext_prev_q <= ext_clk_level;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			ext_sel_q <= 1'b0;
		end else if (ext_clk_level) begin
			ext_sel_q <= 1'b1;
		end
	end

	// watchdog counts oscillator ticks since the last external edge
	always_ff @(posedge clk_sys) begin
		if (rst_int || ext_rise || !ext_sel_q) begin
			watch_q <= 6'h00;
		end else if (osc_tick && watch_q != 6'(dcs_pkg::FS_MIN_OSC)) begin
			watch_q <= watch_q + 6'h01;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int || ext_rise) begin
			fail_q <= 1'b0;
		end else if (ctrl_q.clock_failsafe_enable && watch_q == 6'(dcs_pkg::FS_MIN_OSC)) begin
			fail_q <= 1'b1;
		end
	end

	// once halted only a reset or a returning edge revives the logic
	always_ff @(posedge clk_sys) begin
		if (rst_int || ext_rise) begin
			halt_q <= 1'b0;
		end else if (!ctrl_q.clock_failsafe_enable && watch_q == 6'(dcs_pkg::FS_MIN_OSC)) begin
			halt_q <= 1'b1;
		end
	end

	assign ext_clock_selected = ext_sel_q & ~fail_q;
	assign osc_enable = ~ext_sel_q | fail_q;
	assign logic_halted = halt_q;
	assign low_side_protect_en = ctrl_q.clock_failsafe_enable;
	assign damping_enable = ctrl_q.low_supply_mode;

	////////////////////////////////////////////////////////////////////////////
	// thermal monitor
	logic warn_q;
	logic ot_q;
	logic [7:0] sd_level;

	assign sd_level = ctrl_q.thermal_limit_select ? dcs_pkg::TEMP_SD_LOW
		: dcs_pkg::TEMP_SD_HIGH;

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			warn_q <= 1'b0;
		end else if (run) begin
			warn_q <= at_or_above(temp_deg, dcs_pkg::TEMP_WARN);
		end
	end

	// hysteresis stops the stage from cycling straight back to shutdown
	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			ot_q <= 1'b0;
		end else if (run) begin
			if (at_or_above(temp_deg, sd_level)) begin
				ot_q <= 1'b1;
			end else if (!at_or_above(temp_deg, dcs_pkg::TEMP_RELEASE)) begin
				ot_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			gate_strength <= 3'h0;
		end else if (ctrl_q.gate_temp_comp && warn_q
				&& ctrl_q.high_side_gate_strength != dcs_pkg::GATE_MAX) begin
			gate_strength <= ctrl_q.high_side_gate_strength + 3'h1;
		end else begin
			gate_strength <= ctrl_q.high_side_gate_strength;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// bridge enable
	logic bridge_q;

	// open-load flags deliberately absent here
	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			bridge_q <= 1'b0;
		end else begin
			bridge_q <= !bridge_disable_pin && ctrl_q.chopper_off_time != 4'h0
				&& !ot_q && run;
		end
	end

	// ground short cut is a plain gate, so it still acts with no clock
	assign bridge_enable = bridge_q & ~short_to_ground;

	////////////////////////////////////////////////////////////////////////////
	// open-load detection
	logic [1:0] seen_q;
	logic [1:0] pol_q;
	logic [1:0] ol_q;
	logic [1:0] cur_ok;

	assign cur_ok[0] = at_or_above(coil_i.cur_a, dcs_pkg::CUR_MAX >> dcs_pkg::CUR_DIV_SHIFT);
	assign cur_ok[1] = at_or_above(coil_i.cur_b, dcs_pkg::CUR_MAX >> dcs_pkg::CUR_DIV_SHIFT);

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			pol_q <= 2'h0;
			seen_q <= 2'h0;
			ol_q <= 2'h0;
		end else if (run) begin
			for (int i = 0; i < 2; i++) begin
				pol_q[i] <= coil_i.polarity[i];
				if (coil_i.polarity[i] != pol_q[i]) begin
					if (cur_ok[i]) begin
						ol_q[i] <= ~(seen_q[i] | coil_i.chop_evt[i]);
					end
					seen_q[i] <= 1'b0;
				end else if (coil_i.chop_evt[i]) begin
					seen_q[i] <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// standstill timer
	logic [20:0] standstill_flag_q;
	logic standstill_flag_flag;

	always_ff @(posedge clk_sys) begin
		if (rst_int || step_pulse) begin
			standstill_flag_q <= 21'h0;
		end else if (run && standstill_flag_q != 21'(STANDSTILL_FLAG_CYCLES)) begin
			standstill_flag_q <= standstill_flag_q + 21'h1;
		end
	end

	assign standstill_flag_flag = (standstill_flag_q == 21'(STANDSTILL_FLAG_CYCLES));

	assign flags_o = '{ola: ol_q[0], olb: ol_q[1], thermal_warning_flag: warn_q,
		thermal_shutdown_flag: ot_q, standstill_flag: standstill_flag_flag};

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one wait-free acknowledge per request
	logic req;
	logic [31:0] rd_word;

	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			ctrl_q <= dcs_pkg::dcs_ctrl_t'(dcs_pkg::CTRL_RESET[15:0]);
		end else if (req && wb_we_i && wb_adr_i == dcs_pkg::ADDR_CTRL) begin
			if (wb_sel_i[0]) begin
				ctrl_q[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				ctrl_q[15:8] <= wb_dat_i[15:8];
			end
		end
	end

	always_comb begin
		rd_word = 32'h0;
		unique case (wb_adr_i)
			dcs_pkg::ADDR_CTRL: rd_word[15:0] = ctrl_q;
			dcs_pkg::ADDR_STATUS: rd_word[10:0] = {halt_q, fail_q, ext_sel_q,
				ctrl_q.current_scale, 3'h0};
			default: rd_word = 32'h0;
		endcase
		rd_word[dcs_pkg::RD_OLA] = ol_q[0];
		rd_word[dcs_pkg::RD_OLB] = ol_q[1];
		rd_word[dcs_pkg::RD_WARN] = warn_q;
		rd_word[dcs_pkg::RD_OT] = ot_q;
		rd_word[dcs_pkg::RD_STANDSTILL_FLAG] = standstill_flag_flag;
	end

	always_ff @(posedge clk_sys) begin
		if (rst_int) begin
			wb_dat_o <= 32'h0;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= rd_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	sequence warm_s;
		ctrl_q.gate_temp_comp && warn_q && ctrl_q.high_side_gate_strength != 3'h7;
	endsequence

	ack_one_cycle_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		wb_ack_o |=> !wb_ack_o) else $error("ack held more than one cycle");
	warn_flag_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		run && temp_deg >= 8'h64 |=> warn_q) else $error("warning flag missed");
	shutdown_set_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		run && temp_deg >= sd_level |=> ot_q ##1 !bridge_q) else $error("no shutdown");
	shutdown_hold_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		ot_q && temp_deg >= 8'h78 |=> ot_q) else $error("released above 120");
	limit_select_a: assert property (@(posedge clk_sys)
		sd_level == (ctrl_q.thermal_limit_select ? 8'h88 : 8'h96))
		else $error("wrong shutdown level");
	gate_step_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		warm_s |=> gate_strength == $past(ctrl_q.high_side_gate_strength) + 3'h1)
		else $error("gate not raised");
	uv_clear_a: assert property (@(posedge clk_sys)
		uv_now |=> ctrl_q == '0 && !bridge_q && !wb_ack_o) else $error("uv reset incomplete");
	por_quiet_a: assert property (@(posedge clk_sys)
		power_up_busy |=> !wb_ack_o) else $error("bus answered in power-up");
	disable_pin_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		bridge_disable_pin |=> !bridge_enable) else $error("bridge not freed");
	short_cut_a: assert property (@(posedge clk_sys)
		short_to_ground |-> !bridge_enable) else $error("short not cut");
	standstill_flag_time_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		$rose(standstill_flag_flag) |-> standstill_flag_q == 21'(STANDSTILL_FLAG_CYCLES)) else $error("standstill early");
	failsafe_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		$rose(fail_q) |-> ctrl_q.clock_failsafe_enable && watch_q == 6'h20)
		else $error("failsafe timing");
	halt_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		$rose(halt_q) |-> !ctrl_q.clock_failsafe_enable) else $error("halted with failsafe");
	ext_switch_a: assert property (@(posedge clk_sys) disable iff (rst_int)
		ext_clk_level |=> ext_sel_q) else $error("no switch to external");
endmodule

/* verif/dcs_host.sv */
// host model: register-bus master that configures and polls the supervisor
`timescale 1ns/10ps
module dcs_host (
	input wire logic clk_sys,
	output logic [3:0] adr,
	output logic [31:0] dat_w,
	output logic [3:0] sel,
	output logic we,
	output logic cyc,
	output logic stb,
	input wire logic [31:0] dat_r,
	input wire logic ack
);
	initial begin
		{adr, dat_w, sel, we, cyc, stb} = '0;
	end
	// open-load bits are polled on every read, including the thermal reads before the polarity flips
	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
		input int lim, output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		dat_w <= d;
		sel <= 4'h3;
		cyc <= 1'b1;
		stb <= 1'b1;
		@(posedge clk_sys);
		while (ack !== 1'b1 && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
		ok = (ack === 1'b1);
		q = dat_r;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk_sys);
	endtask
endmodule

/* verif/dcs_supervisor_test.sv */
// self-checking bench for the supervisor, host model on the register bus
`timescale 1ns/10ps
module dcs_supervisor_test;
	localparam int STANDSTILL_FLAG = 64;
	logic clk_sys, sys_rst, pub, b7, b45, step, ext, ext_run, dis, s2g, we, cyc, stb, ack;
	logic ok, be, lsp, damp, ext_sel, osc_en, halted, sd;
	logic [7:0] temp, t;
	logic [3:0] adr, sel;
	logic [31:0] dat_w, dat_r, q;
	logic [2:0] gate;
	logic [7:0] corner [10];
	dcs_pkg::dcs_coil_t coil;
	dcs_pkg::dcs_flags_t flags;
	int fails, cmp_count, cycles, seed;
	dcs_supervisor #(.STANDSTILL_FLAG_CYCLES(STANDSTILL_FLAG)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.wb_adr_i(adr), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_sel_i(sel), .wb_we_i(we),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .power_up_busy(pub),
		.supply_below_7v(b7), .supply_below_4v5(b45), .temp_deg(temp), .coil_i(coil),
		.step_pulse(step), .ext_clk_level(ext), .bridge_disable_pin(dis),
		.short_to_ground(s2g), .bridge_enable(be), .gate_strength(gate),
		.low_side_protect_en(lsp), .damping_enable(damp), .ext_clock_selected(ext_sel),
		.osc_enable(osc_en), .logic_halted(halted), .flags_o(flags));
	dcs_host host (.clk_sys(clk_sys), .adr(adr), .dat_w(dat_w), .sel(sel), .we(we),
		.cyc(cyc), .stb(stb), .dat_r(dat_r), .ack(ack));
	//////////////////////////////////////////////////////////////////////////
	function automatic logic [2:0] exp_gate(input logic [2:0] g, input logic w);
		return (w && g != 3'h7) ? g + 3'h1 : g;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		host.xfer(a, 1'b1, d, 20, q, ok);
		chk("write ack", 1, ok);
	endtask
	task automatic rd(input logic [3:0] a);
		host.xfer(a, 1'b0, '0, 20, q, ok);
		chk("read ack", 1, ok);
	endtask
	// pulse one supply comparator, then leave a clear edge before the next request
	task automatic uv(input logic seven);
		if (seven) b7 <= 1'b1;
		else b45 <= 1'b1;
		wait_cyc(3);
		b7 <= 1'b0;
		b45 <= 1'b0;
		wait_cyc(1);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// external clock pin toggles at half rate; pulled down while stopped
	always @(posedge clk_sys) begin
		ext <= ext_run & ~ext;
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		corner = '{8'h63, 8'h64, 8'h87, 8'h88, 8'h95, 8'h96, 8'h7D, 8'h78, 8'h77, 8'h19};
		seed = 32'hea1bf60f;
		{sys_rst, pub, b7, b45, ext, ext_run, dis, s2g, sd} = 9'h100;
		step = 1'b1;
		temp = 8'h19;
		coil = '0;
		fails = 0;
		cmp_count = 0;
		cycles = 0;
		wait_cyc(8);
		sys_rst <= 1'b0;
		pub <= 1'b1;
		@(posedge clk_sys);
		host.xfer(4'h0, 1'b0, '0, 10, q, ok);
		chk("ack in power-up", 0, ok);
		pub <= 1'b0;
		wait_cyc(1);
		rd(4'h8);
		chk("unmapped read", 0, q);
		rd(4'h0);
		chk("ctrl reset", 0, q);
		chk("bridge off time 0", 0, be);
		$display("test reset done");
		wr(4'h0, 32'h0000_A8D8);
		rd(4'h0);
		chk("ctrl readback", 32'h0000_A8D8, q);
		wr(4'h4, 32'hFFFF_FFFF);
		rd(4'h4);
		chk("scale readback", 5'h15, q[7:3]);
		chk("bridge on", 1, be);
		dis <= 1'b1;
		wait_cyc(3);
		chk("disable pin", 0, be);
		dis <= 1'b0;
		s2g <= 1'b1;
		wait_cyc(3);
		chk("short cuts bridge", 0, be);
		s2g <= 1'b0;
		wr(4'h0, 32'h0000_A858);
		chk("off time zero", 0, be);
		$display("test bridge done");
		for (int s = 0; s < 2; s++) begin
			wr(4'h0, 32'h0000_A8D8 | s);
			for (int i = 0; i < 30; i++) begin
				t = (i < 10) ? corner[i] : 8'($unsigned($random(seed)) % 160);
				temp <= t;
				wait_cyc(3);
				sd = (t >= (s ? dcs_pkg::TEMP_SD_LOW : dcs_pkg::TEMP_SD_HIGH)) |
					(sd & (t >= dcs_pkg::TEMP_RELEASE));
				chk("warning", t >= dcs_pkg::TEMP_WARN, flags.thermal_warning_flag);
				chk("shutdown", sd, flags.thermal_shutdown_flag);
				chk("bridge vs heat", !sd, be);
				chk("gate", exp_gate(3'h3, t >= dcs_pkg::TEMP_WARN), gate);
			end
			rd(4'h0);
			chk("flags in read", {2'b0, t >= dcs_pkg::TEMP_WARN, sd, 1'b0}, q[31:27]);
		end
		$display("test thermal done");
		temp <= 8'h19;
		coil <= {2'b00, 2'b00, 8'hC8, 8'h0E};
		wait_cyc(4);
		coil.polarity <= 2'b11;
		wait_cyc(4);
		chk("open load a", 1, flags.ola);
		chk("low current frozen", 0, flags.olb);
		chk("no action", 1, be);
		coil.chop_evt <= 2'b01;
		coil.cur_b <= 8'h0F;
		wait_cyc(1);
		coil.chop_evt <= 2'b00;
		wait_cyc(2);
		coil.polarity <= 2'b00;
		wait_cyc(4);
		rd(4'h0);
		chk("open load read", 5'b01000, q[31:27]);
		$display("test open load done");
		uv(1'b0);
		rd(4'h4);
		chk("4v5 ignored", 5'h15, q[7:3]);
		uv(1'b1);
		rd(4'h4);
		chk("scale cleared", 0, q[7:3]);
		rd(4'h0);
		chk("ctrl cleared", 0, q);
		wr(4'h0, 32'h0000_A8DA);
		chk("damping", 1, damp);
		uv(1'b1);
		rd(4'h4);
		chk("7v ignored", 5'h15, q[7:3]);
		uv(1'b0);
		rd(4'h4);
		chk("4v5 clears", 0, q[7:3]);
		$display("test undervoltage done");
		wr(4'h0, 32'h0000_A8D8);
		step <= 1'b0;
		wait_cyc(STANDSTILL_FLAG - 4);
		chk("standstill early", 0, flags.standstill_flag);
		wait_cyc(8);
		chk("standstill", 1, flags.standstill_flag);
		step <= 1'b1;
		$display("test standstill done");
		dis <= 1'b1;
		ext_run <= 1'b1;
		wait_cyc(6);
		chk("external selected", 1, ext_sel);
		chk("osc off", 0, osc_en);
		ext_run <= 1'b0;
		wait_cyc(480);
		chk("halted", 1, halted);
		ext_run <= 1'b1;
		wait_cyc(6);
		chk("resumed", 0, halted);
		wr(4'h0, 32'h0000_A8DC);
		chk("low side protect", 1, lsp);
		ext_run <= 1'b0;
		wait_cyc(420);
		chk("failover early", 0, osc_en);
		wait_cyc(260);
		chk("failover osc", 1, osc_en);
		rd(4'h4);
		chk("clock failed bit", 3'b011, q[10:8]);
		$display("test clock done");
		end_of_test();
	end
endmodule
